// ==== spi_far_slave.sv ====
// behavioural spi slave standing at the far end of the master port
module spi_far_slave (
    // clock and load
    input wire logic pclk,
    input wire logic load,
    // bus mode
    input wire logic idle_clock_level,
    input wire logic cke,
    // serial lines
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    // byte side
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_q;
    logic [7:0] sh_q;
    logic [2:0] cnt_q;
    logic lead;
    logic trail;
    // leading edge leaves idle level, trailing edge returns to it
    assign lead = (sclk ^ idle_clock_level) && !(prev_q ^ idle_clock_level);
    assign trail = !(sclk ^ idle_clock_level) && (prev_q ^ idle_clock_level);
    always @(posedge pclk) begin
        prev_q <= sclk;
        if (load) begin
            sh_q <= tx_byte;
            cnt_q <= 3'h0;
            miso <= tx_byte[7];
        end else if ((lead && cke) || (trail && !cke)) begin
            sh_q <= {sh_q[6:0], mosi};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
                rx_byte <= {sh_q[6:0], mosi};
            end
        end else if ((trail && cke) || (lead && !cke)) begin
            miso <= sh_q[7];
        end
    end
endmodule

// ==== spi_half_tick.sv ====
// half bit clock tick generator for master mode
module spi_half_tick
    import sync_serial_spi_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic hold,
    input wire logic [3:0] mode,
    input wire logic [7:0] period,
    // tick out
    output logic tick
);
    logic [7:0] cnt_q;
    logic [7:0] reload;

    // rate select, timer rate uses one timer period per half bit
    always_comb begin
        unique case (mode)
            MODE_MASTER_DIV4: reload = HALF_DIV4;
            MODE_MASTER_DIV16: reload = HALF_DIV16;
            MODE_MASTER_DIV64: reload = HALF_DIV64;
            default: reload = period;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= BYTE_RESET;
        end else if (!run) begin
            cnt_q <= reload;
        end else if (!hold) begin
            if (cnt_q == BYTE_RESET) begin
                cnt_q <= reload;
            end else begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end

    assign tick = run && !hold && (cnt_q == BYTE_RESET);
endmodule

// ==== sync_serial_spi_pkg.sv ====
// shared constants and types of the synchronous serial port
package sync_serial_spi_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_BUFFER = 8'h08;
    localparam logic [7:0] OFS_PERIOD = 8'h0c;
    localparam logic [7:0] OFS_AUX = 8'h10;

    // port_control_one fields
    localparam int CTL_WRITE_COLLISION_FLAG_BIT = 7;
    localparam int CTL_OVF_BIT = 6;
    localparam int CTL_EN_BIT = 5;
    localparam int CTL_CKP_BIT = 4;
    localparam int CTL_MODE_HI = 3;
    localparam int CTL_MODE_LO = 0;

    // port_status_reg fields
    localparam int STS_SMP_BIT = 7;
    localparam int STS_CKE_BIT = 6;
    localparam int STS_BF_BIT = 0;

    // auxiliary control fields
    localparam int AUX_FLAG_BIT = 0;
    localparam int AUX_WAKE_EN_BIT = 1;
    localparam int AUX_SDO_DIS_BIT = 2;
    localparam int AUX_BUSY_BIT = 3;

    // port_mode_field codes
    localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
    localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
    localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
    localparam logic [3:0] MODE_MASTER_TIMER = 4'h3;
    localparam logic [3:0] MODE_SLAVE_SEL = 4'h4;
    localparam logic [3:0] MODE_SLAVE_FREE = 4'h5;

    // half bit reload counts (cycles minus one)
    localparam logic [7:0] HALF_DIV4 = 8'h01;
    localparam logic [7:0] HALF_DIV16 = 8'h07;
    localparam logic [7:0] HALF_DIV64 = 8'h1f;

    // reset values and byte geometry
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [4:0] EDGE_LAST = 5'h0f;
    localparam logic [4:0] EDGE_ZERO = 5'h00;

    typedef enum {M_IDLE, M_SHIFT, M_DRAIN} master_state_t;

endpackage

// ==== sync_serial_spi_port.sv ====
// byte wide synchronous serial port, master or slave, with apb registers
//
// Decided for this implementation: register access over APB and the register offsets.
module sync_serial_spi_port
    import sync_serial_spi_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial clock pin
    input wire logic serial_clock_in,
    output logic serial_clock_out,
    output logic serial_clock_oe,
    input wire logic clock_return_input,
    // data and select pins
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    input wire logic slave_select_n,
    // power management
    input wire logic sleep_mode,
    output logic wake_request
);
    // config and status
    logic port_enable_q, idle_clock_level_q, input_sample_phase_q, launch_edge_q;
    logic [3:0] port_mode_field_q;
    logic [7:0] timer_period_reg_q, transfer_buffer_q;
    logic wake_en_q, sdo_dis_q;
    logic write_collision_flag_q, receive_overflow_flag_q;
    logic buffer_full_flag_q, port_interrupt_flag_q;
    // apb outputs
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    // synchronisers
    logic sck_m, sck_s, sck_p, ret_m, ret_s, ret_p, sdi_m, sdi_s, ss_m, ss_s;
    logic smp_ev_q, smp_bit_q;
    // shifter
    master_state_t mstate_q;
    logic [4:0] edge_q;
    logic [3:0] bitcnt_q;
    logic [7:0] tx_q, rx_q;
    logic got_byte_q, sdo_q, sdo_oe_q, sck_q, sck_oe_q, wake_q;

    logic is_master, is_slave, sel_ctl, port_reset, busy, tick;
    logic access, wr_done, rd_done, hit;
    logic wr_ctl, wr_sts, wr_buf, wr_per, wr_aux, rd_buf;
    logic load, collide, commit, overflow, launch_tick, shift_out;
    logic m_sample, s_sample, s_launch, sample_ev, sample_bit;
    logic [31:0] rd_mux;
    logic [7:0] rx_next;

    // mode decode
    assign is_master = port_enable_q && (port_mode_field_q <= MODE_MASTER_TIMER);
    assign is_slave = port_enable_q && (port_mode_field_q == MODE_SLAVE_SEL
        || port_mode_field_q == MODE_SLAVE_FREE);
    assign sel_ctl = port_mode_field_q == MODE_SLAVE_SEL;
    assign port_reset = !port_enable_q || (is_slave && sel_ctl && ss_s);
    assign busy = (mstate_q != M_IDLE) || (is_slave && bitcnt_q != BIT_ZERO);

    // apb decode, one wait state per transfer
    assign access = psel && penable;
    assign wr_done = access && pready_q && pwrite;
    assign rd_done = access && pready_q && !pwrite;
    assign hit = paddr == OFS_CONTROL_ONE || paddr == OFS_STATUS || paddr == OFS_BUFFER
        || paddr == OFS_PERIOD || paddr == OFS_AUX;
    assign wr_ctl = wr_done && paddr == OFS_CONTROL_ONE;
    assign wr_sts = wr_done && paddr == OFS_STATUS;
    assign wr_buf = wr_done && paddr == OFS_BUFFER;
    assign wr_per = wr_done && paddr == OFS_PERIOD;
    assign wr_aux = wr_done && paddr == OFS_AUX;
    assign rd_buf = rd_done && paddr == OFS_BUFFER;
    assign load = wr_buf && !busy && (is_master || is_slave);
    assign collide = wr_buf && busy;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            OFS_CONTROL_ONE: begin
                rd_mux[CTL_WRITE_COLLISION_FLAG_BIT] = write_collision_flag_q;
                rd_mux[CTL_OVF_BIT] = receive_overflow_flag_q;
                rd_mux[CTL_EN_BIT] = port_enable_q;
                rd_mux[CTL_CKP_BIT] = idle_clock_level_q;
                rd_mux[CTL_MODE_HI:CTL_MODE_LO] = port_mode_field_q;
            end
            OFS_STATUS: begin
                rd_mux[STS_SMP_BIT] = input_sample_phase_q;
                rd_mux[STS_CKE_BIT] = launch_edge_q;
                rd_mux[STS_BF_BIT] = buffer_full_flag_q;
            end
            OFS_BUFFER: rd_mux[7:0] = transfer_buffer_q;
            OFS_PERIOD: rd_mux[7:0] = timer_period_reg_q;
            OFS_AUX: begin
                rd_mux[AUX_FLAG_BIT] = port_interrupt_flag_q;
                rd_mux[AUX_WAKE_EN_BIT] = wake_en_q;
                rd_mux[AUX_SDO_DIS_BIT] = sdo_dis_q;
                rd_mux[AUX_BUSY_BIT] = busy;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access && !pready_q;
            if (access && !pready_q) begin
                prdata_q <= rd_mux;
                pslverr_q <= !hit;
            end
        end
    end

    // configuration registers, cleared by device reset except the timer period, which resets to all ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_enable_q <= 1'b0;
            idle_clock_level_q <= 1'b0;
            port_mode_field_q <= MODE_MASTER_DIV4;
            input_sample_phase_q <= 1'b0;
            launch_edge_q <= 1'b0;
            timer_period_reg_q <= PERIOD_RESET;
            wake_en_q <= 1'b0;
            sdo_dis_q <= 1'b0;
        end else begin
            if (wr_ctl) begin
                port_enable_q <= pwdata[CTL_EN_BIT];
                idle_clock_level_q <= pwdata[CTL_CKP_BIT];
                port_mode_field_q <= pwdata[CTL_MODE_HI:CTL_MODE_LO];
            end
            if (wr_sts) begin
                input_sample_phase_q <= pwdata[STS_SMP_BIT];
                launch_edge_q <= pwdata[STS_CKE_BIT];
            end
            if (wr_per) begin
                timer_period_reg_q <= pwdata[7:0];
            end
            if (wr_aux) begin
                wake_en_q <= pwdata[AUX_WAKE_EN_BIT];
                sdo_dis_q <= pwdata[AUX_SDO_DIS_BIT];
            end
        end
    end

    // sticky flags, hardware set wins over software clear
    assign overflow = commit && is_slave && buffer_full_flag_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_collision_flag_q <= 1'b0;
            receive_overflow_flag_q <= 1'b0;
            buffer_full_flag_q <= 1'b0;
            port_interrupt_flag_q <= 1'b0;
            transfer_buffer_q <= BYTE_RESET;
        end else begin
            if (collide) begin
                write_collision_flag_q <= 1'b1;
            end else if (wr_ctl && !pwdata[CTL_WRITE_COLLISION_FLAG_BIT]) begin
                write_collision_flag_q <= 1'b0;
            end
            if (overflow) begin
                receive_overflow_flag_q <= 1'b1;
            end else if (wr_ctl && !pwdata[CTL_OVF_BIT]) begin
                receive_overflow_flag_q <= 1'b0;
            end
            if (commit) begin
                buffer_full_flag_q <= 1'b1;
            end else if (rd_buf) begin
                buffer_full_flag_q <= 1'b0;
            end
            if (commit) begin
                port_interrupt_flag_q <= 1'b1;
            end else if (wr_aux && pwdata[AUX_FLAG_BIT]) begin
                port_interrupt_flag_q <= 1'b0;
            end
            if (commit && !overflow) begin
                transfer_buffer_q <= rx_next;
            end
        end
    end

    // pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_m <= 1'b0;
            sck_s <= 1'b0;
            sck_p <= 1'b0;
            ret_m <= 1'b0;
            ret_s <= 1'b0;
            ret_p <= 1'b0;
            sdi_m <= 1'b0;
            sdi_s <= 1'b0;
            ss_m <= 1'b1;
            ss_s <= 1'b1;
        end else begin
            sck_m <= serial_clock_in;
            sck_s <= sck_m;
            sck_p <= sck_s;
            ret_m <= clock_return_input;
            ret_s <= ret_m;
            ret_p <= ret_s;
            sdi_m <= serial_data_in;
            sdi_s <= sdi_m;
            ss_m <= slave_select_n;
            ss_s <= ss_m;
        end
    end

    // sample on leading edge when launch select set, else trailing
    assign m_sample = (mstate_q != M_IDLE) && (ret_s != ret_p)
        && ((ret_s != idle_clock_level_q) == launch_edge_q);
    assign s_sample = is_slave && !port_reset && (sck_s != sck_p)
        && ((sck_s != idle_clock_level_q) == launch_edge_q);
    assign s_launch = is_slave && !port_reset && (sck_s != sck_p)
        && ((sck_s != idle_clock_level_q) != launch_edge_q);

    // later sample phase delays master capture by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smp_ev_q <= 1'b0;
            smp_bit_q <= 1'b0;
        end else begin
            smp_ev_q <= m_sample;
            smp_bit_q <= sdi_s;
        end
    end

    assign sample_ev = s_sample || (input_sample_phase_q ? smp_ev_q : m_sample);
    assign sample_bit = (is_master && input_sample_phase_q) ? smp_bit_q : sdi_s;
    assign rx_next = {rx_q[6:0], sample_bit};
    assign commit = sample_ev && bitcnt_q == BIT_LAST;

    // receive shifter and bit counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_q <= BYTE_RESET;
            bitcnt_q <= BIT_ZERO;
        end else if (port_reset || load) begin
            bitcnt_q <= BIT_ZERO;
        end else if (sample_ev) begin
            rx_q <= rx_next;
            bitcnt_q <= commit ? BIT_ZERO : bitcnt_q + 4'h1;
        end
    end

    spi_half_tick u_half_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(mstate_q == M_SHIFT),
        .hold(sleep_mode),
        .mode(port_mode_field_q),
        .period(timer_period_reg_q),
        .tick(tick)
    );

    // launch on odd half ticks with launch select set, even otherwise
    assign launch_tick = tick && (edge_q[0] == launch_edge_q);
    assign shift_out = (is_master && mstate_q == M_SHIFT && launch_tick) || s_launch;

    // master sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mstate_q <= M_IDLE;
            edge_q <= EDGE_ZERO;
            got_byte_q <= 1'b0;
        end else if (!is_master) begin
            mstate_q <= M_IDLE;
            edge_q <= EDGE_ZERO;
            got_byte_q <= 1'b0;
        end else begin
            unique case (mstate_q)
                M_IDLE: begin
                    if (load) begin
                        mstate_q <= M_SHIFT;
                        edge_q <= EDGE_ZERO;
                        got_byte_q <= 1'b0;
                    end
                end
                M_SHIFT: begin
                    if (commit) begin
                        got_byte_q <= 1'b1;
                    end
                    if (tick) begin
                        edge_q <= edge_q + 5'h01;
                        if (edge_q == EDGE_LAST) begin
                            mstate_q <= M_DRAIN;
                        end
                    end
                end
                M_DRAIN: begin
                    if (commit || got_byte_q) begin
                        mstate_q <= M_IDLE;
                    end
                end
            endcase
        end
    end

    // transmit shifter and data pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_q <= BYTE_RESET;
            sdo_q <= 1'b0;
        end else if (load) begin
            if (launch_edge_q) begin
                sdo_q <= pwdata[7];
                tx_q <= {pwdata[6:0], 1'b0};
            end else begin
                tx_q <= pwdata[7:0];
            end
        end else if (shift_out) begin
            sdo_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // pin drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_q <= 1'b0;
            sck_oe_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            sck_oe_q <= is_master;
            sdo_oe_q <= !sdo_dis_q && (is_master || (is_slave && !(sel_ctl && ss_s)));
            wake_q <= port_interrupt_flag_q && wake_en_q;
            if (!is_master || mstate_q != M_SHIFT) begin
                sck_q <= idle_clock_level_q;
            end else if (tick) begin
                sck_q <= !sck_q;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign serial_clock_out = sck_q;
    assign serial_clock_oe = sck_oe_q;
    assign serial_data_out = sdo_q;
    assign serial_data_oe = sdo_oe_q;
    assign wake_request = wake_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_DISABLED_RELEASE: assert property (!port_enable_q ##1 !port_enable_q |->
        !serial_clock_oe && !serial_data_oe && mstate_q == M_IDLE)
        else $error("pins driven while port disabled");
    AST_START: assert property (is_master && !busy && wr_buf |=>
        mstate_q == M_SHIFT && edge_q == EDGE_ZERO)
        else $error("buffer write did not start master transfer");
    AST_EARLY_DATA: assert property (load && launch_edge_q |=>
        serial_data_out == $past(pwdata[7]))
        else $error("first bit not presented at load");
    AST_FULL_FLAG: assert property (commit |=> buffer_full_flag_q && port_interrupt_flag_q)
        else $error("byte completion did not set full and flag");
    AST_COLLIDE: assert property (collide |=> write_collision_flag_q &&
        tx_q == ($past(shift_out) ? {$past(tx_q[6:0]), 1'b0} : $past(tx_q)))
        else $error("collision not flagged");
    AST_OVERFLOW: assert property (overflow |=> receive_overflow_flag_q &&
        $stable(transfer_buffer_q))
        else $error("overflow byte not discarded");
    AST_SEL_FLOAT: assert property (is_slave && sel_ctl && ss_s |=>
        !serial_data_oe && bitcnt_q == BIT_ZERO)
        else $error("select high did not float output and reset counter");
    AST_SLEEP_FREEZE: assert property (mstate_q == M_SHIFT && sleep_mode &&
        is_master |=> $stable(edge_q) && $stable(serial_clock_out))
        else $error("master advanced during sleep");
    AST_IDLE_CLOCK: assert property (is_master && mstate_q == M_IDLE ##1 is_master |->
        serial_clock_out == $past(idle_clock_level_q))
        else $error("idle clock level wrong");
    AST_WAKE: assert property (port_interrupt_flag_q && wake_en_q |=> wake_request)
        else $error("wake not raised");
endmodule

// ==== tb_top.sv ====
// self-checking bench of the serial port in master and slave modes over apb
module tb_top;
    import sync_serial_spi_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, perr, sco, scoe, sdo, sdoe, miso, sclk_w, idle_clock_level, cke, load = 0, held;
    logic [7:0] txb, rxb;
    logic wake, sel_n = 1, mtog = 0;
    int miscompares = 0, num_checks = 0;
    always #12.5 pclk = ~pclk;
    // clock loops back through the pin, bench toggles it in slave role
    assign sclk_w = scoe ? sco : idle_clock_level ^ mtog;
    sync_serial_spi_port sync_serial_spi_port_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_clock_in(sclk_w),
        .serial_clock_out(sco), .serial_clock_oe(scoe), .clock_return_input(sclk_w),
        .serial_data_in(miso), .serial_data_out(sdo), .serial_data_oe(sdoe),
        .slave_select_n(sel_n), .sleep_mode(sleep_mode), .wake_request(wake));
    spi_far_slave spi_far_slave_inst (.pclk(pclk), .load(load), .idle_clock_level(idle_clock_level), .cke(cke),
        .sclk(sclk_w), .mosi(sdoe ? sdo : ~sdo), .miso(miso), .tx_byte(txb), .rx_byte(rxb));
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            print_verdict();
        end
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_AUX, 32'h0);
            n++;
        end while (rdata[AUX_BUSY_BIT] !== 1'b0 && n < 400);
        if (n >= 400) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic slave_clock(input int edges);
        repeat (edges) begin
            repeat (4) @(posedge pclk);
            mtog <= ~mtog;
        end
        repeat (8) @(posedge pclk);
    endtask
    initial begin
        idle_clock_level = 1'b0;
        cke = 1'b0;
        txb = 8'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CONTROL_ONE, 32'h0);
        check("control reset", rdata, 32'h0);
        apb(1'b0, OFS_PERIOD, 32'h0);
        check("period reset", rdata, {24'h0, PERIOD_RESET});
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped err", perr, 1'b1);
        apb(1'b1, OFS_PERIOD, 32'h2);
        for (int i = 0; i < 4; i++) begin
            idle_clock_level <= i[1];
            cke <= ~i[0];
            txb <= 8'h3c + i[7:0];
            load <= 1'b1;
            apb(1'b1, OFS_STATUS, {24'h0, i == 2, ~i[0], 6'h0});
            load <= 1'b0;
            apb(1'b1, OFS_AUX, {29'h0, i == 3, 2'b10});
            apb(1'b1, OFS_CONTROL_ONE, {26'h1, idle_clock_level, i[3:0]});
            repeat (2) @(posedge pclk);
            check("clock idle", {scoe, sco}, {1'b1, idle_clock_level});
            apb(1'b1, OFS_BUFFER, 8'ha5 + i[7:0]);
            apb(1'b1, OFS_BUFFER, 32'h0);
            check("data oe", sdoe, i != 3);
            if (i == 0) begin
                sleep_mode <= 1'b1;
                @(posedge pclk);
                held = sco;
                repeat (20) @(posedge pclk);
                check("frozen clock", sco, held);
                sleep_mode <= 1'b0;
            end
            wait_idle();
            check("aux done", rdata, {29'h0, i == 3, 2'b11});
            check("wake", wake, 1'b1);
            if (i != 3) check("far rx", rxb, 8'ha5 + i[7:0]);
            apb(1'b0, OFS_CONTROL_ONE, 32'h0);
            check("collision", rdata, {24'h0, 2'b10, 1'b1, idle_clock_level, i[3:0]});
            apb(1'b0, OFS_STATUS, 32'h0);
            check("full set", rdata, {24'h0, i == 2, cke, 6'h1});
            apb(1'b0, OFS_BUFFER, 32'h0);
            check("rx byte", rdata, {24'h0, txb});
            apb(1'b0, OFS_STATUS, 32'h0);
            check("full clear", rdata, {24'h0, i == 2, cke, 6'h0});
            apb(1'b1, OFS_AUX, 32'h1);
            apb(1'b1, OFS_CONTROL_ONE, 32'h0);
            apb(1'b0, OFS_CONTROL_ONE, 32'h0);
            check("disabled", {rdata[7:0], scoe}, 9'h0);
        end
        // slave role with select control, bench drives the serial clock
        idle_clock_level <= 1'b0;
        cke <= 1'b1;
        txb <= 8'h69;
        load <= 1'b1;
        apb(1'b1, OFS_STATUS, 32'h40);
        load <= 1'b0;
        apb(1'b1, OFS_AUX, 32'h2);
        apb(1'b1, OFS_CONTROL_ONE, {26'h1, 1'b0, MODE_SLAVE_SEL});
        sel_n <= 1'b0;
        apb(1'b1, OFS_BUFFER, 32'h81);
        slave_clock(16);
        check("slave far rx", rxb, 8'h81);
        apb(1'b0, OFS_AUX, 32'h0);
        check("slave flag", rdata, 32'h3);
        check("slave wake", wake, 1'b1);
        slave_clock(16);
        apb(1'b0, OFS_CONTROL_ONE, 32'h0);
        check("slave overflow", rdata, 32'h64);
        apb(1'b0, OFS_BUFFER, 32'h0);
        check("slave rx byte", rdata, 32'h69);
        slave_clock(2);
        check("slave drive", sdoe, 1'b1);
        sel_n <= 1'b1;
        repeat (4) @(posedge pclk);
        check("slave float", sdoe, 1'b0);
        apb(1'b0, OFS_AUX, 32'h0);
        check("select reset", rdata, 32'h3);
        // device reset in the middle of a master transfer
        apb(1'b1, OFS_CONTROL_ONE, 32'h0);
        apb(1'b1, OFS_CONTROL_ONE, 32'h20);
        apb(1'b1, OFS_BUFFER, 32'h5a);
        repeat (6) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check("reset pins", {scoe, sdoe, sco}, 3'h0);
        apb(1'b0, OFS_AUX, 32'h0);
        check("reset aux", rdata, 32'h0);
        apb(1'b0, OFS_PERIOD, 32'h0);
        check("reset period", rdata, {24'h0, PERIOD_RESET});
        print_verdict();
    end
endmodule
